// File: rtl/asx_exec.sv
// Executor for accumulator store, register transfer and watchdog restart words.
// Assumes instruction words, accumulator and watchdog event share clock_i.
`timescale 1ns/1ns
module asx_exec (
  input  wire logic                clock_i,
  input  wire logic                resetn_i,
  input  wire logic                clk_en_i,
  input  wire asx_pkg::asx_instr_s instr_i,
  input  wire asx_pkg::asx_acc_s   acc_i,
  input  wire logic                wdt_flag_set_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output asx_pkg::asx_accwb_s      acc_wb_o,
  output asx_pkg::asx_periph_s     periph_o,
  output logic                     skip_o,
  output logic                     irq_o
);
  import asx_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  logic [3:0]            nib_q [NIB_COUNT];
  logic [7:0]            byte_q [BYTE_COUNT];
  logic                  port_bit_q;
  logic                  clksrc_bit_q;
  logic [NIB_COUNT-1:0]  nib_ld;
  logic [BYTE_COUNT-1:0] byte_ld;
  asx_op_e               opk;
  logic [3:0]            imm;
  logic                  take;
  logic                  run;
  logic                  drop;
  logic [3:0]            ram_q [256];
  logic [7:0]            dp;
  logic [3:0]            ram_rd;
  logic                  ram_we;
  logic [3:0]            x_q;
  logic [3:0]            x_d;
  logic [3:0]            y_q;
  logic [3:0]            y_d;
  logic [3:0]            y_dec;
  logic                  skip_q;
  logic                  skip_d;
  logic                  wdf_q;
  logic                  wdf_d;
  asx_accwb_s            accwb_q;
  asx_accwb_s            accwb_d;
  logic                  ev_wdt;
  logic                  ev_row;
  logic [ST_W-1:0]       status_q;
  logic [ST_W-1:0]       status_d;
  logic [ST_W-1:0]       mask_q;
  logic [ST_W-1:0]       mask_d;
  logic                  exec_en_q;
  logic                  exec_en_d;
  logic                  ack_q;
  logic                  ack_d;
  logic [31:0]           rdata_q;
  logic [31:0]           rdata_d;
  logic                  wb_req;
  logic                  wb_wr;

  // Instruction decode; a pending skip swallows exactly one word.
  assign take = instr_i.valid & exec_en_q;
  assign drop = take & skip_q;
  assign run  = take & ~skip_q;
  assign imm  = instr_i.word[3:0];

  always_comb
  begin
    opk     = OPK_NONE;
    nib_ld  = '0;
    byte_ld = '0;
    for (int i = 0; i < NIB_COUNT; i++)
    begin
      if (instr_i.word == NIB_OPS[i])
      begin
        opk       = OPK_NIB;
        nib_ld[i] = run;
      end
    end
    for (int i = 0; i < BYTE_COUNT; i++)
    begin
      if (instr_i.word == BYTE_OPS[i])
      begin
        opk        = OPK_PAIR;
        byte_ld[i] = run;
      end
    end
    case (instr_i.word[9:4])
      OPH_STORE_ACC_TO_RAM:       opk = OPK_STORE;
      OPH_SWAP_ACC_RAM:           opk = OPK_SWAP;
      OPH_SWAP_ACC_RAM_DECREMENT: opk = OPK_SWAP_DEC;
      default: ;
    endcase
    case (instr_i.word)
      OP_LOAD_PORT_CTRL_BIT:    opk = OPK_PORT;
      OP_LOAD_CLOCK_SOURCE_BIT: opk = OPK_CLKSRC;
      OP_LOAD_ROW_POINTER:      opk = OPK_ROW;
      OP_WATCHDOG_RESTART_OP:   opk = OPK_WDT;
      default: ;
    endcase
  end

  // Control registers behind the transfer opcodes.
  for (genvar g = 0; g < NIB_COUNT; g++)
  begin : g_nib
    asx_hold_reg #(.W(4)) u_reg (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .clk_en_i (clk_en_i),
      .load_i   (nib_ld[g]),
      .d_i      (acc_i.a),
      .q_o      (nib_q[g])
    );
    assign periph_o.nib[g] = nib_q[g];
  end

  for (genvar g = 0; g < BYTE_COUNT; g++)
  begin : g_byte
    asx_hold_reg #(.W(8)) u_reg (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .clk_en_i (clk_en_i),
      .load_i   (byte_ld[g]),
      .d_i      ({acc_i.b, acc_i.a}),
      .q_o      (byte_q[g])
    );
    assign periph_o.byt[g] = byte_q[g];
  end

  asx_hold_reg #(.W(1)) u_port_bit (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .load_i   (run && opk == OPK_PORT),
    .d_i      (acc_i.a[0]),
    .q_o      (port_bit_q)
  );

  asx_hold_reg #(.W(1)) u_clksrc_bit (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .load_i   (run && opk == OPK_CLKSRC),
    .d_i      (acc_i.a[0]),
    .q_o      (clksrc_bit_q)
  );

  assign periph_o.port_bit   = port_bit_q;
  assign periph_o.clksrc_bit = clksrc_bit_q;

  // Pointer, RAM, skip and watchdog flag.
  assign dp     = {x_q, y_q};
  assign ram_rd = ram_q[dp];
  assign y_dec  = y_q - 4'h1;

  always_comb
  begin
    x_d     = x_q;
    y_d     = y_q;
    skip_d  = skip_q;
    accwb_d = '0;
    ev_wdt  = 1'b0;
    ev_row  = 1'b0;
    ram_we  = 1'b0;
    if (drop)
      skip_d = 1'b0;
    if (run)
    begin
      case (opk)
        OPK_STORE:
        begin
          ram_we = 1'b1;
          x_d    = x_q ^ imm;
        end
        OPK_SWAP, OPK_SWAP_DEC:
        begin
          ram_we  = 1'b1;
          accwb_d = '{wr: 1'b1, data: ram_rd};
          x_d     = x_q ^ imm;
          if (opk == OPK_SWAP_DEC)
          begin
            y_d    = y_dec;
            skip_d = (y_dec == ROW_WRAP);
            ev_row = (y_dec == ROW_WRAP);
          end
        end
        OPK_ROW: y_d = acc_i.a;
        OPK_WDT:
        begin
          skip_d = wdf_q;
          ev_wdt = wdf_q;
        end
        default: ;
      endcase
    end
    wdf_d = wdt_flag_set_i | (wdf_q & ~ev_wdt);
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      x_q     <= 4'h0;
      y_q     <= 4'h0;
      skip_q  <= 1'b0;
      wdf_q   <= 1'b0;
      accwb_q <= '0;
    end
    else if (clk_en_i)
    begin
      x_q     <= x_d;
      y_q     <= y_d;
      skip_q  <= skip_d;
      wdf_q   <= wdf_d;
      accwb_q <= accwb_d;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (clk_en_i && ram_we)
      ram_q[dp] <= acc_i.a;
  end

  assign skip_o   = skip_q;
  assign acc_wb_o = accwb_q;

  // Wishbone slave with status, mask and control.
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

  always_comb
  begin
    ack_d     = wb_req;
    rdata_d   = 32'h0;
    mask_d    = mask_q;
    exec_en_d = exec_en_q;
    status_d  = status_q;
    if (wb_wr && wb_adr_i == REG_STATUS)
      status_d = status_q & ~wb_dat_i[ST_W-1:0];
    if (wb_wr && wb_adr_i == REG_MASK)
      mask_d = wb_dat_i[ST_W-1:0];
    if (wb_wr && wb_adr_i == REG_CTRL)
      exec_en_d = wb_dat_i[CTRL_EXEC_BIT];
    status_d[ST_WDT_SKIP] = status_d[ST_WDT_SKIP] | ev_wdt;
    status_d[ST_ROW_SKIP] = status_d[ST_ROW_SKIP] | ev_row;
    status_d[ST_DROPPED]  = status_d[ST_DROPPED] | drop;
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        REG_WAKEUP:  rdata_d = {24'h0, nib_q[NI_K2], nib_q[NI_K1]};
        REG_CLOCK:   rdata_d = {27'h0, clksrc_bit_q, nib_q[NI_MR]};
        REG_PORT:    rdata_d = {23'h0, port_bit_q, nib_q[NI_PU1], nib_q[NI_PU0]};
        REG_ADC:     rdata_d = {20'h0, nib_q[NI_Q3], nib_q[NI_Q2], nib_q[NI_Q1]};
        REG_PRESC:   rdata_d = {16'h0, byte_q[BI_RPS], byte_q[BI_TPS]};
        REG_RELOAD:  rdata_d = {16'h0, byte_q[BI_R3], byte_q[BI_R1]};
        REG_SERIAL:  rdata_d = {24'h0, byte_q[BI_SI]};
        REG_IRQCTL:  rdata_d = {24'h0, nib_q[NI_V2], nib_q[NI_V1]};
        REG_TIMER:   rdata_d = {8'h0, nib_q[15], nib_q[14], nib_q[13], nib_q[12],
                                nib_q[11], nib_q[NI_W1]};
        REG_POINTER: rdata_d = {23'h0, wdf_q, y_q, x_q};
        REG_STATUS:  rdata_d = {29'h0, status_q};
        REG_MASK:    rdata_d = {29'h0, mask_q};
        REG_CTRL:    rdata_d = {31'h0, exec_en_q};
        default:     rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h0;
      status_q  <= STATUS_RESET;
      mask_q    <= MASK_RESET;
      exec_en_q <= CTRL_EXEC_RESET;
    end
    else if (clk_en_i)
    begin
      ack_q     <= ack_d;
      rdata_q   <= rdata_d;
      status_q  <= status_d;
      mask_q    <= mask_d;
      exec_en_q <= exec_en_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign irq_o    = |(status_q & mask_q);

  // Checks.

  plain_no_skip_a: assert property (clk_en_i && run && opk inside {OPK_NIB, OPK_PAIR,
      OPK_PORT, OPK_CLKSRC, OPK_ROW, OPK_STORE, OPK_SWAP} |=> !skip_q)
    else $error("Plain transfer raised a skip.");
  wakeup_load_a: assert property (clk_en_i && nib_ld[NI_K1]
      |=> nib_q[NI_K1] == $past(acc_i.a))
    else $error("Wakeup register did not take the accumulator.");
  store_xor_a: assert property (clk_en_i && run && opk == OPK_STORE
      |=> x_q == ($past(x_q) ^ $past(imm)) && ram_q[$past(dp)] == $past(acc_i.a))
    else $error("Store did not write RAM or update column pointer.");
  port_bit_a: assert property (clk_en_i && run && opk == OPK_PORT
      |=> port_bit_q == $past(acc_i.a[0]))
    else $error("Port control bit wrong after load.");
  prescaler_pair_a: assert property (clk_en_i && byte_ld[BI_TPS]
      |=> byte_q[BI_TPS] == {$past(acc_i.b), $past(acc_i.a)}
          && byte_q[BI_RPS] == byte_q[BI_TPS])
    else $error("Prescaler pair not loaded together.");
  row_load_a: assert property (clk_en_i && run && opk == OPK_ROW
      |=> y_q == $past(acc_i.a) && !skip_q)
    else $error("Row pointer load wrong.");
  wdt_skip_a: assert property (clk_en_i && run && opk == OPK_WDT && wdf_q
      && !wdt_flag_set_i |=> skip_q && !wdf_q && status_q[ST_WDT_SKIP])
    else $error("Watchdog restart did not skip and clear.");
  skip_drop_a: assert property (clk_en_i && drop
      |=> !skip_q && status_q[ST_DROPPED])
    else $error("Pending skip did not discard one word.");
  wdt_pass_a: assert property (clk_en_i && run && opk == OPK_WDT && !wdf_q
      |=> !skip_q)
    else $error("Watchdog restart skipped with flag clear.");
  swap_back_a: assert property (clk_en_i && run && opk == OPK_SWAP
      |=> acc_wb_o.wr && acc_wb_o.data == $past(ram_rd)
          && ram_q[$past(dp)] == $past(acc_i.a))
    else $error("Exchange lost a nibble.");
  row_wrap_a: assert property (clk_en_i && run && opk == OPK_SWAP_DEC && y_q == 4'h0
      |=> y_q == ROW_WRAP && skip_q && status_q[ST_ROW_SKIP])
    else $error("Row wrap did not skip.");
  bus_ack_a: assert property (clk_en_i && wb_req ##1 clk_en_i |-> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not a single cycle.");

  wdt_skip_c: cover property (clk_en_i && run && opk == OPK_WDT && wdf_q);
  row_wrap_c: cover property (clk_en_i && run && opk == OPK_SWAP_DEC && y_q == 4'h0);
  dropped_c: cover property (clk_en_i && drop);
  irq_c: cover property (irq_o);

endmodule : asx_exec

// File: rtl/asx_hold_reg.sv
// Loadable holding register with clock enable.
// Assumes load_i and d_i come from logic on the same clock.
`timescale 1ns/1ns
module asx_hold_reg #(
  parameter int           W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  input  wire logic         clk_en_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  always_comb
  begin
    q_d = load_i ? d_i : q_q;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      q_q <= RST;
    else if (clk_en_i)
      q_q <= q_d;
  end

  assign q_o = q_q;

endmodule : asx_hold_reg

// File: rtl/asx_pkg.sv
// Shared constants, opcodes, register map and carrier types for the store executor.
// Assumes one core clock; the instruction source and the accumulator share it.
package asx_pkg;

  // Nibble control register slots, in load-opcode order.
  localparam int NI_K1 = 0;
  localparam int NI_K2 = 1;
  localparam int NI_MR = 2;
  localparam int NI_PU0 = 3;
  localparam int NI_PU1 = 4;
  localparam int NI_Q1 = 5;
  localparam int NI_Q2 = 6;
  localparam int NI_Q3 = 7;
  localparam int NI_V1 = 8;
  localparam int NI_V2 = 9;
  localparam int NI_W1 = 10;
  localparam int NIB_COUNT = 16;

  // Byte registers loaded as {B, A}.
  localparam int BI_TPS = 0;
  localparam int BI_RPS = 1;
  localparam int BI_R1 = 2;
  localparam int BI_R3 = 3;
  localparam int BI_SI = 4;
  localparam int BYTE_COUNT = 5;

  localparam logic [9:0] NIB_OPS [NIB_COUNT] = '{
    10'h214, 10'h215, 10'h216, 10'h22d, 10'h22e, 10'h204, 10'h205, 10'h206,
    10'h03f, 10'h03e, 10'h20e, 10'h20f, 10'h210, 10'h211, 10'h212, 10'h213};
  localparam logic [9:0] BYTE_OPS [BYTE_COUNT] = '{
    10'h235, 10'h235, 10'h23f, 10'h23b, 10'h238};

  localparam logic [9:0] OP_LOAD_PORT_CTRL_BIT     = 10'h2aa;
  localparam logic [9:0] OP_LOAD_CLOCK_SOURCE_BIT  = 10'h209;
  localparam logic [9:0] OP_LOAD_ROW_POINTER       = 10'h00c;
  localparam logic [9:0] OP_WATCHDOG_RESTART_OP    = 10'h2a0;
  localparam logic [5:0] OPH_STORE_ACC_TO_RAM      = 6'h2b;
  localparam logic [5:0] OPH_SWAP_ACC_RAM          = 6'h2d;
  localparam logic [5:0] OPH_SWAP_ACC_RAM_DECREMENT = 6'h2f;

  localparam logic [3:0] ROW_WRAP = 4'hf;

  // Wishbone byte offsets.
  localparam logic [7:0] REG_WAKEUP  = 8'h00;
  localparam logic [7:0] REG_CLOCK   = 8'h04;
  localparam logic [7:0] REG_PORT    = 8'h08;
  localparam logic [7:0] REG_ADC     = 8'h0c;
  localparam logic [7:0] REG_PRESC   = 8'h10;
  localparam logic [7:0] REG_RELOAD  = 8'h14;
  localparam logic [7:0] REG_SERIAL  = 8'h18;
  localparam logic [7:0] REG_IRQCTL  = 8'h1c;
  localparam logic [7:0] REG_TIMER   = 8'h20;
  localparam logic [7:0] REG_POINTER = 8'h24;
  localparam logic [7:0] REG_STATUS  = 8'h28;
  localparam logic [7:0] REG_MASK    = 8'h2c;
  localparam logic [7:0] REG_CTRL    = 8'h30;

  localparam int ST_WDT_SKIP = 0;
  localparam int ST_ROW_SKIP = 1;
  localparam int ST_DROPPED  = 2;
  localparam int ST_W        = 3;
  localparam logic [ST_W-1:0] STATUS_RESET = 3'h0;
  localparam logic [ST_W-1:0] MASK_RESET   = 3'h0;
  localparam int CTRL_EXEC_BIT = 0;
  localparam logic CTRL_EXEC_RESET = 1'b1;

  typedef struct packed {
    logic       valid;
    logic [9:0] word;
  } asx_instr_s;

  typedef struct packed {
    logic [3:0] b;
    logic [3:0] a;
  } asx_acc_s;

  typedef struct packed {
    logic       wr;
    logic [3:0] data;
  } asx_accwb_s;

  typedef struct packed {
    logic [NIB_COUNT-1:0][3:0]  nib;
    logic [BYTE_COUNT-1:0][7:0] byt;
    logic                       port_bit;
    logic                       clksrc_bit;
  } asx_periph_s;

  typedef enum logic [3:0] {
    OPK_NONE, OPK_NIB, OPK_PAIR, OPK_PORT, OPK_CLKSRC,
    OPK_STORE, OPK_SWAP, OPK_SWAP_DEC, OPK_ROW, OPK_WDT
  } asx_op_e;

endpackage : asx_pkg

// File: test/accumulator_store_instruction_exec_tb_top.sv
// Bench for the store executor: program store model, bus master, reference model.
// Assumes one 250 MHz clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module accumulator_store_instruction_exec_tb_top;
  import asx_pkg::*;
  logic        clock_i   = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        clk_en_i  = 1'b1;
  logic        stall     = 1'b0;
  logic        wdt_set   = 1'b0;
  logic        cyc       = 1'b0;
  logic        we        = 1'b0;
  logic [3:0]  sel       = 4'h0;
  logic [7:0]  adr       = 8'h00;
  logic [31:0] wdat      = 32'h0;
  logic [31:0] rdat;
  logic [31:0] r;
  logic        ack;
  logic        skip;
  logic        irq;
  logic        rnd       = 1'b0;
  logic        chk_on    = 1'b0;
  asx_acc_s    acc       = '0;
  asx_instr_s  instr;
  asx_accwb_s  accwb;
  asx_periph_s per;
  int          errors    = 0;
  int          cmp_count = 0;
  int          seed      = 3;
  logic [3:0]  m_nib [NIB_COUNT];
  logic [7:0]  m_byt [BYTE_COUNT];
  logic [3:0]  ram [int];
  logic [3:0]  m_x, m_y, m_wd;
  logic [2:0]  m_st, m_mask;
  logic        m_port, m_src, m_flag, m_skip, m_wr, m_exec;

  always #2 clock_i = ~clock_i;

  asx_rom_model u_rom (.clock_i(clock_i), .resetn_i(resetn_i), .adv_i(clk_en_i),
                       .stall_i(stall), .instr_o(instr));

  asx_exec DUT (.clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
                .instr_i(instr), .acc_i(acc), .wdt_flag_set_i(wdt_set),
                .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
                .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
                .acc_wb_o(accwb), .periph_o(per), .skip_o(skip), .irq_o(irq));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic chk_state(input string n, input logic [127:0] e, input logic [127:0] g);
    cmp_count++;
    if (e !== g)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_state

  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc  <= 1'b1;
    sel  <= 4'hf;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
    begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    sel <= 4'h0;
    we  <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      final_report();
    end
    if (w && a == REG_MASK)
      m_mask = d[2:0];
    if (w && a == REG_STATUS)
      m_st = m_st & ~d[2:0];
    if (w && a == REG_CTRL)
      m_exec = d[0];
  endtask : wb_xfer

  task automatic chk_bus(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] rd;
    wb_xfer(1'b0, a, 32'h0, rd);
    chk_state("wb_read", e & m, rd & m);
  endtask : chk_bus

  function automatic asx_periph_s exp_per();
    asx_periph_s e;
    for (int i = 0; i < NIB_COUNT; i++)
      e.nib[i] = m_nib[i];
    for (int i = 0; i < BYTE_COUNT; i++)
      e.byt[i] = m_byt[i];
    e.port_bit = m_port;
    e.clksrc_bit = m_src;
    return e;
  endfunction : exp_per

  task automatic exec_word(input logic [9:0] w, input asx_acc_s v);
    logic [7:0] p;
    p = {m_x, m_y};
    if (m_skip)
    begin
      m_skip = 1'b0;
      m_st[ST_DROPPED] = 1'b1;
      return;
    end
    for (int i = 0; i < NIB_COUNT; i++)
      if (w == NIB_OPS[i])
        m_nib[i] = v.a;
    case (w)
      BYTE_OPS[BI_TPS]:
      begin
        m_byt[BI_TPS] = v;
        m_byt[BI_RPS] = v;
      end
      BYTE_OPS[BI_R1]: m_byt[BI_R1] = v;
      BYTE_OPS[BI_R3]: m_byt[BI_R3] = v;
      BYTE_OPS[BI_SI]: m_byt[BI_SI] = v;
      OP_LOAD_PORT_CTRL_BIT: m_port = v.a[0];
      OP_LOAD_CLOCK_SOURCE_BIT: m_src = v.a[0];
      OP_LOAD_ROW_POINTER: m_y = v.a;
      OP_WATCHDOG_RESTART_OP:
        if (m_flag)
        begin
          m_skip = 1'b1;
          m_flag = 1'b0;
          m_st[ST_WDT_SKIP] = 1'b1;
        end
      default: ;
    endcase
    if (w[9:4] == OPH_STORE_ACC_TO_RAM)
      ram[p] = v.a;
    if (w[9:4] == OPH_SWAP_ACC_RAM || w[9:4] == OPH_SWAP_ACC_RAM_DECREMENT)
    begin
      m_wr = 1'b1;
      m_wd = ram.exists(p) ? ram[p] : 4'hx;
      ram[p] = v.a;
    end
    if (w[9:4] inside {OPH_STORE_ACC_TO_RAM, OPH_SWAP_ACC_RAM, OPH_SWAP_ACC_RAM_DECREMENT})
      m_x = m_x ^ w[3:0];
    if (w[9:4] == OPH_SWAP_ACC_RAM_DECREMENT)
    begin
      m_y = m_y - 4'h1;
      if (m_y == ROW_WRAP)
      begin
        m_skip = 1'b1;
        m_st[ST_ROW_SKIP] = 1'b1;
      end
    end
  endtask : exec_word

  // Reference step on every enabled edge; a set event wins over the restart clear.
  always @(posedge clock_i)
  begin
    if (resetn_i && clk_en_i)
    begin
      m_wr = 1'b0;
      if (instr.valid === 1'b1 && m_exec)
        exec_word(instr.word, acc);
      if (wdt_set)
        m_flag = 1'b1;
    end
    acc      <= 8'($random(seed));
    wdt_set  <= rnd && (($random(seed) % 6) == 0);
    stall    <= rnd && ($random(seed) % 3 == 0);
    clk_en_i <= !rnd || ($random(seed) % 4 != 0);
  end

  always @(negedge clock_i)
  begin
    if (chk_on && resetn_i)
    begin
      chk_state("periph", exp_per(), per);
      chk_state("skip", m_skip, skip);
      chk_state("swap_wr", m_wr, accwb.wr);
      if (m_wr)
        chk_state("swap_data", m_wd, accwb.data);
      chk_state("irq", |(m_st & m_mask), irq);
    end
  end

  task automatic run_rand(input int n);
    logic [31:0] v;
    repeat (n)
    begin
      v = $random(seed);
      case (v[7:4] % 10)
        0: u_rom.push(NIB_OPS[v[11:8]]);
        1: u_rom.push(BYTE_OPS[v[10:8] % 5]);
        2: u_rom.push(OP_LOAD_PORT_CTRL_BIT);
        3: u_rom.push(OP_LOAD_CLOCK_SOURCE_BIT);
        4: u_rom.push(OP_LOAD_ROW_POINTER);
        5: u_rom.push(OP_WATCHDOG_RESTART_OP);
        6: u_rom.push({OPH_STORE_ACC_TO_RAM, v[3:0]});
        7: u_rom.push({OPH_SWAP_ACC_RAM, v[3:0]});
        8: u_rom.push({OPH_SWAP_ACC_RAM_DECREMENT, v[3:0]});
        default: u_rom.push(10'h3ff);
      endcase
    end
  endtask : run_rand

  task automatic drain();
    int n;
    n = 0;
    while ((u_rom.q.size() != 0 || instr.valid !== 1'b0) && n < 20000)
    begin
      @(posedge clock_i);
      n++;
    end
    rnd = 1'b0;
    repeat (2) @(posedge clock_i);
    if (n >= 20000)
    begin
      errors++;
      final_report();
    end
  endtask : drain

  initial
  begin
    repeat (90000) @(posedge clock_i);
    errors++;
    final_report();
  end

  initial
  begin
    m_nib = '{default: 4'h0};
    m_byt = '{default: 8'h00};
    {m_x, m_y, m_wd, m_st, m_mask} = '0;
    {m_port, m_src, m_flag, m_skip, m_wr} = '0;
    m_exec = 1'b1;
    repeat (10) @(posedge clock_i);
    resetn_i <= 1'b1;
    chk_on = 1'b1;
    chk_bus(REG_STATUS, 32'h0, 32'hffffffff);
    chk_bus(REG_MASK, 32'h0, 32'hffffffff);
    chk_bus(REG_CTRL, 32'h1, 32'hffffffff);
    chk_bus(8'h40, 32'h0, 32'hffffffff);
    $display("test reset_values done");
    for (int i = 0; i < NIB_COUNT; i++)
      u_rom.push(NIB_OPS[i]);
    for (int i = 0; i < BYTE_COUNT; i++)
      u_rom.push(BYTE_OPS[i]);
    u_rom.push(OP_LOAD_PORT_CTRL_BIT);
    u_rom.push(OP_LOAD_CLOCK_SOURCE_BIT);
    u_rom.push(OP_LOAD_ROW_POINTER);
    u_rom.push(OP_WATCHDOG_RESTART_OP);
    for (int j = 0; j < 16; j++)
    begin
      u_rom.push({OPH_STORE_ACC_TO_RAM, 4'(j)});
      u_rom.push({OPH_SWAP_ACC_RAM, 4'(j)});
      u_rom.push({OPH_SWAP_ACC_RAM_DECREMENT, 4'(j)});
    end
    drain();
    $display("test every_opcode done");
    rnd = 1'b1;
    run_rand(400);
    drain();
    $display("test random_stream done");
    chk_bus(REG_WAKEUP, {m_nib[NI_K2], m_nib[NI_K1]}, 32'hff);
    chk_bus(REG_PRESC, {m_byt[BI_RPS], m_byt[BI_TPS]}, 32'hffff);
    chk_bus(REG_CLOCK, {m_src, m_nib[NI_MR]}, 32'hffffffff);
    chk_bus(REG_PORT, {m_port, m_nib[NI_PU1], m_nib[NI_PU0]}, 32'hffffffff);
    chk_bus(REG_ADC, {m_nib[NI_Q3], m_nib[NI_Q2], m_nib[NI_Q1]}, 32'hffffffff);
    chk_bus(REG_RELOAD, {m_byt[BI_R3], m_byt[BI_R1]}, 32'hffffffff);
    chk_bus(REG_SERIAL, m_byt[BI_SI], 32'hffffffff);
    chk_bus(REG_IRQCTL, {m_nib[NI_V2], m_nib[NI_V1]}, 32'hffffffff);
    chk_bus(REG_TIMER, {m_nib[15], m_nib[14], m_nib[13], m_nib[12], m_nib[11],
                        m_nib[NI_W1]}, 32'hffffffff);
    chk_bus(REG_POINTER, {m_flag, m_y, m_x}, 32'h1ff);
    wb_xfer(1'b1, REG_WAKEUP, 32'hffffffff, r);
    chk_bus(REG_WAKEUP, {m_nib[NI_K2], m_nib[NI_K1]}, 32'hff);
    chk_bus(REG_STATUS, m_st, 32'h7);
    $display("test readback done");
    wb_xfer(1'b1, REG_MASK, 32'h7, r);
    repeat (3) @(posedge clock_i);
    wb_xfer(1'b1, REG_STATUS, 32'h7, r);
    chk_bus(REG_STATUS, 32'h0, 32'h7);
    wb_xfer(1'b1, REG_MASK, 32'h5, r);
    rnd = 1'b1;
    run_rand(150);
    drain();
    $display("test interrupt done");
    wb_xfer(1'b1, REG_CTRL, 32'h0, r);
    run_rand(30);
    drain();
    wb_xfer(1'b1, REG_CTRL, 32'h1, r);
    chk_bus(REG_CTRL, 32'h1, 32'h1);
    $display("test exec_disable done");
    final_report();
  end
endmodule : accumulator_store_instruction_exec_tb_top

// File: test/asx_rom_model.sv
// Program store model: hands queued words to the executor at most one per enabled edge, none while stalled.
// Assumes the bench pushes words and drives advance and stall on clock_i.
`timescale 1ns/1ns
module asx_rom_model (
  input  wire logic           clock_i,
  input  wire logic           resetn_i,
  input  wire logic           adv_i,
  input  wire logic           stall_i,
  output asx_pkg::asx_instr_s instr_o
);
  import asx_pkg::*;
  logic [9:0] q [$];

  task automatic push(input logic [9:0] w);
    q.push_back(w);
  endtask : push

  // An idle word bus alternates between the inverse of the last word and the last word itself.
  always @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      instr_o <= '0;
    else if (adv_i)
    begin
      if (instr_o.valid && q.size() > 0)
        void'(q.pop_front());
      if (!stall_i && q.size() > 0)
        instr_o <= '{valid: 1'b1, word: q[0]};
      else
        instr_o <= '{valid: 1'b0, word: ~instr_o.word};
    end
  end
endmodule : asx_rom_model
